/* File: logic/etc_pkg.sv */
package etc_pkg;
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [3:0] OFS_CONTROL  = 4'h0;
  localparam logic [3:0] OFS_LOW      = 4'h4;
  localparam logic [3:0] OFS_HIGH_BUF = 4'h8;
  localparam logic [3:0] OFS_STATUS   = 4'hC;
  // Mask register shares the status layout.
  localparam logic [4:0] OFS_MASK     = 5'h10;
  // Control field positions.
  localparam int BIT_RUN    = 7;
  localparam int BIT_WIDTH8 = 6;
  localparam int BIT_EXTSRC = 5;
  localparam int BIT_FALL   = 4;
  localparam int BIT_BYPASS = 3;
  localparam int BIT_OVF    = 0;
  // Values after reset.
  localparam logic [7:0] RST_CONTROL = 8'hFF;
  localparam logic [7:0] RST_ZERO    = 8'h00;
  // The 40 MHz bus clock divided by four gives the instruction cycle.
  localparam int         CLK_MHZ        = 40;
  localparam int         INSTR_CLKS     = 4;
  localparam logic [1:0] INSTR_LAST     = 2'(INSTR_CLKS - 1);
  localparam logic [1:0] WRITE_INHIBIT  = 2'h2;
  localparam logic [1:0] AXI_OKAY       = 2'h0;
  localparam logic [1:0] AXI_SLVERR     = 2'h2;

  typedef enum logic [1:0] {ETC_IDLE, ETC_RESP} etc_bus_st_t;

  // Complete state of the timer block.
  typedef struct packed {
    logic [7:0]  control;
    logic [15:0] count;
    logic [7:0]  high_buf;
    logic [7:0]  presc;
    logic [1:0]  phase;
    logic [1:0]  inhibit;
    logic        ovf_flag;
    logic        ovf_mask;
    logic        irq;
    logic [2:0]  pin_sync;
    logic        pin_level;
    etc_bus_st_t wst;
    logic        awv;
    logic        wv;
    logic [4:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    etc_bus_st_t rst;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        awrdy;
    logic        wrdy;
    logic        ardy;
  } etc_state_t;
endpackage

/* File: logic/etc_timer.sv */
`timescale 1ns/1ps
// What this block does
// RULE_01: Width select set gives an 8-bit counter, cleared gives 16 bits.
// RULE_02: Overflow is signalled on wrap FFh to 00h or FFFFh to 0000h.
// RULE_03: Run enable set lets the counter advance; cleared halts it.
// RULE_04: Clock source set counts pin edges; cleared counts instruction cycles.
// RULE_05: Timer mode without prescaler increments once per instruction cycle.
// RULE_06: Source edge cleared counts rising pin edges; set counts falling ones.
// RULE_07: Prescaler bypass set feeds the counter directly, cleared via prescaler.
// RULE_08: Prescale code 000 divides by 2 up to code 111 dividing by 256.
// RULE_09: The prescaler is a dedicated 8-bit counter; software sets only its ratio and cannot read or write its count.
// RULE_10: A counter write in timer mode blocks increments for two instruction cycles.
// RULE_11: Pin edges are synchronised before they can increment the counter.
// RULE_12: A counter write clears the prescaler count, keeping its assignment.
// RULE_13: Overflow sets a sticky flag; interrupt only when enabled; software clears.
// RULE_14: In 16-bit mode a low byte read copies the high byte into the buffer.
// RULE_15: In 16-bit mode a low byte write loads the high byte from the buffer.
// RULE_16: While halted the counter holds its value and raises no overflow.
module etc_timer (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        external_count_input,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);
  etc_pkg::etc_state_t q;
  etc_pkg::etc_state_t d;

  logic       wr_fire;
  logic       rd_fire;
  logic       instr_tick;
  logic       pin_edge;
  logic       src_tick;
  logic       presc_hit;
  logic       cnt_tick;
  logic       wrap;
  logic       low_wr;
  logic       low_rd;
  logic       status_clr;
  logic [7:0] wbyte;
  logic [7:0] presc_mask;

  // Ready flags follow from the held state, so they come from flip-flops.
  assign s_axi_awready = q.awrdy;
  assign s_axi_wready  = q.wrdy;
  assign s_axi_arready = q.ardy;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign irq           = q.irq;

  // Decode of the pending bus accesses and the counter tick chain.
  always_comb
  begin
    wr_fire    = q.awv && q.wv && (q.wst == etc_pkg::ETC_IDLE);
    rd_fire    = s_axi_arvalid && q.ardy;
    wbyte      = q.wdata[7:0];
    low_wr     = wr_fire && q.wstrb[0] && (q.awaddr == 5'(etc_pkg::OFS_LOW));
    low_rd     = rd_fire && (s_axi_araddr == 5'(etc_pkg::OFS_LOW));
    status_clr = wr_fire && q.wstrb[0] && (q.awaddr == 5'(etc_pkg::OFS_STATUS)) &&
                 wbyte[etc_pkg::BIT_OVF];
    instr_tick = (q.phase == etc_pkg::INSTR_LAST);
    // Only the agreeing second and third stages are compared.
    pin_edge   = (q.pin_sync[2] == q.pin_sync[1]) && (q.pin_sync[1] != q.pin_level) &&
                 (q.pin_sync[1] ^ q.control[etc_pkg::BIT_FALL]); // RULE_06 RULE_11
    src_tick   = q.control[etc_pkg::BIT_EXTSRC] ? pin_edge
               : (instr_tick && (q.inhibit == 2'h0)); // RULE_04 RULE_05 RULE_10
    presc_mask = 8'((9'h002 << q.control[2:0]) - 9'h001); // RULE_08
    presc_hit  = ((q.presc & presc_mask) == presc_mask);
    cnt_tick   = q.control[etc_pkg::BIT_RUN] && src_tick &&
                 (q.control[etc_pkg::BIT_BYPASS] || presc_hit); // RULE_03 RULE_07 RULE_16
    wrap       = cnt_tick && (q.count[7:0] == 8'hFF) &&
                 (q.control[etc_pkg::BIT_WIDTH8] || (q.count[15:8] == 8'hFF)); // RULE_01 RULE_02
  end

  // Next state of the whole block.
  always_comb
  begin
    d = q;
    d.pin_sync  = {q.pin_sync[1:0], external_count_input}; // RULE_11
    if (q.pin_sync[2] == q.pin_sync[1])
    begin
      d.pin_level = q.pin_sync[1];
    end
    d.phase = (q.phase == etc_pkg::INSTR_LAST) ? 2'h0 : 2'(q.phase + 2'h1);
    if (instr_tick && (q.inhibit != 2'h0))
    begin
      d.inhibit = 2'(q.inhibit - 2'h1);
    end
    // The prescaler advances on every source tick while it is assigned and the run enable is set.
    if (q.control[etc_pkg::BIT_RUN] && src_tick && !q.control[etc_pkg::BIT_BYPASS])
    begin
      d.presc = 8'(q.presc + 8'h01); // RULE_09
    end
    if (cnt_tick)
    begin
      if (q.control[etc_pkg::BIT_WIDTH8])
      begin
        d.count[7:0] = 8'(q.count[7:0] + 8'h01); // RULE_01
      end
      else
      begin
        d.count = 16'(q.count + 16'h0001); // RULE_01
      end
    end
    if (low_rd && !q.control[etc_pkg::BIT_WIDTH8])
    begin
      d.high_buf = q.count[15:8]; // RULE_14
    end
    // Write response and register updates.
    if (s_axi_awvalid && s_axi_awready)
    begin
      d.awv    = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      d.wv    = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      d.awv    = 1'b0;
      d.wv     = 1'b0;
      d.wst    = etc_pkg::ETC_RESP;
      d.bvalid = 1'b1;
      d.bresp  = etc_pkg::AXI_OKAY;
      if (q.wstrb[0])
      begin
        case (q.awaddr)
          5'(etc_pkg::OFS_CONTROL):  d.control  = wbyte;
          5'(etc_pkg::OFS_HIGH_BUF): d.high_buf = wbyte;
          5'(etc_pkg::OFS_MASK):     d.ovf_mask = wbyte[etc_pkg::BIT_OVF];
          5'(etc_pkg::OFS_STATUS):
          begin
            if (wbyte[etc_pkg::BIT_OVF])
            begin
              d.ovf_flag = 1'b0; // RULE_13
            end
          end
          5'(etc_pkg::OFS_LOW):
          begin
            d.count[7:0] = wbyte;
            if (!q.control[etc_pkg::BIT_WIDTH8])
            begin
              d.count[15:8] = q.high_buf; // RULE_15
            end
            d.presc   = etc_pkg::RST_ZERO; // RULE_12
            d.inhibit = etc_pkg::WRITE_INHIBIT; // RULE_10
          end
          default:
          begin
            d.bresp = etc_pkg::AXI_SLVERR;
          end
        endcase
      end
      else if (q.awaddr > etc_pkg::OFS_MASK || q.awaddr[1:0] != 2'h0)
      begin
        d.bresp = etc_pkg::AXI_SLVERR;
      end
    end
    if (q.wst == etc_pkg::ETC_RESP && s_axi_bready)
    begin
      d.bvalid = 1'b0;
      d.wst    = etc_pkg::ETC_IDLE;
    end
    // An overflow in the same cycle as the clear keeps the flag set.
    if (wrap)
    begin
      d.ovf_flag = 1'b1; // RULE_02 RULE_13
    end
    d.irq = d.ovf_flag && d.ovf_mask; // RULE_13
    // Read path.
    if (rd_fire)
    begin
      d.rst    = etc_pkg::ETC_RESP;
      d.rvalid = 1'b1;
      d.rresp  = etc_pkg::AXI_OKAY;
      d.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        5'(etc_pkg::OFS_CONTROL):  d.rdata[7:0] = q.control;
        5'(etc_pkg::OFS_LOW):      d.rdata[7:0] = q.count[7:0];
        5'(etc_pkg::OFS_HIGH_BUF): d.rdata[7:0] = q.high_buf;
        5'(etc_pkg::OFS_STATUS):   d.rdata[0]   = q.ovf_flag;
        5'(etc_pkg::OFS_MASK):     d.rdata[0]   = q.ovf_mask;
        default:                   d.rresp      = etc_pkg::AXI_SLVERR;
      endcase
    end
    if (q.rst == etc_pkg::ETC_RESP && s_axi_rready)
    begin
      d.rvalid = 1'b0;
      d.rst    = etc_pkg::ETC_IDLE;
    end
    // Ready flags are registered from the next state, so each bus output leaves a flop.
    d.awrdy = (d.wst == etc_pkg::ETC_IDLE) && !d.awv;
    d.wrdy  = (d.wst == etc_pkg::ETC_IDLE) && !d.wv;
    d.ardy  = (d.rst == etc_pkg::ETC_IDLE);
  end

  // State register with synchronous reset and a global clock enable.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q          <= '0;
      q.control  <= etc_pkg::RST_CONTROL;
      q.wst      <= etc_pkg::ETC_IDLE;
      q.rst      <= etc_pkg::ETC_IDLE;
    end
    else if (clk_en)
    begin
      q <= d;
    end
  end

  sequence s_halted;
    clk_en && !q.control[etc_pkg::BIT_RUN] && !wr_fire;
  endsequence

  AST_WIDTH8_HIGH_HOLD: assert property (@(posedge clk) disable iff (reset) // RULE_01
    (clk_en && q.control[etc_pkg::BIT_WIDTH8] && !wr_fire) |=> $stable(q.count[15:8]))
    else $error("high byte moved in 8-bit mode");
  AST_WRAP_FLAG: assert property (@(posedge clk) disable iff (reset) // RULE_02
    (clk_en && wrap && !low_wr) |=> q.ovf_flag && q.count[7:0] == 8'h00)
    else $error("wrap did not set flag");
  AST_HALT_HOLD: assert property (@(posedge clk) disable iff (reset) // RULE_03
    s_halted |=> $stable(q.count))
    else $error("count moved while halted");
  AST_INSTR_RATE: assert property (@(posedge clk) disable iff (reset) // RULE_05
    (cnt_tick && !q.control[etc_pkg::BIT_EXTSRC]) |-> instr_tick)
    else $error("timer tick off the instruction cycle");
  AST_EXT_SYNC: assert property (@(posedge clk) disable iff (reset) // RULE_11
    (cnt_tick && q.control[etc_pkg::BIT_EXTSRC]) |-> q.pin_sync[2] == q.pin_sync[1])
    else $error("unsynchronised external tick");
  AST_PRESC_CLEAR: assert property (@(posedge clk) disable iff (reset) // RULE_12
    (clk_en && low_wr) |=> q.presc == 8'h00)
    else $error("prescaler not cleared by write");
  AST_INHIBIT: assert property (@(posedge clk) disable iff (reset) // RULE_10
    (clk_en && low_wr) |=> q.inhibit == 2'h2)
    else $error("write inhibit not armed");
  AST_IRQ_GATE: assert property (@(posedge clk) disable iff (reset) // RULE_13
    q.irq |-> $past(q.ovf_mask) || q.ovf_mask)
    else $error("interrupt while masked");
  AST_HALT_NO_OVF: assert property (@(posedge clk) disable iff (reset) // RULE_16
    !q.control[etc_pkg::BIT_RUN] |-> !wrap)
    else $error("overflow while halted");
  AST_LOW_READ_COPY: assert property (@(posedge clk) disable iff (reset) // RULE_14
    (clk_en && low_rd && !q.control[etc_pkg::BIT_WIDTH8] && !wr_fire)
    |=> q.high_buf == $past(q.count[15:8]))
    else $error("high byte not buffered on low read");
  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (reset) // RULE_13
    (clk_en && q.ovf_flag && !status_clr) |=> q.ovf_flag)
    else $error("overflow flag dropped without a clear");
  AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (reset) // RULE_13
    (clk_en && status_clr && !wrap) |=> !q.ovf_flag)
    else $error("overflow flag survived a clear");
  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (reset) // RULE_13
    q.irq == (q.ovf_flag && q.ovf_mask))
    else $error("interrupt line disagrees with flag and mask");
  AST_LOW_WRITE_LOAD: assert property (@(posedge clk) disable iff (reset) // RULE_15
    (clk_en && low_wr && !q.control[etc_pkg::BIT_WIDTH8]) |=>
    q.count == {$past(q.high_buf), $past(wbyte)})
    else $error("sixteen bits not loaded together");
  AST_INHIBIT_BLOCK: assert property (@(posedge clk) disable iff (reset) // RULE_10
    (q.inhibit != 2'h0 && !q.control[etc_pkg::BIT_EXTSRC]) |-> !cnt_tick)
    else $error("timer advanced inside the write inhibit");
  AST_PRESC_WRAP: assert property (@(posedge clk) disable iff (reset) // RULE_08
    (clk_en && cnt_tick && !q.control[etc_pkg::BIT_BYPASS] && !wr_fire)
    |=> (q.presc & presc_mask) == 8'h00)
    else $error("prescaler did not restart after its ratio");

  // A settled pin level that differs from the last one in the selected direction is one counted edge.
  sequence s_edge_armed;
    clk_en && q.control[etc_pkg::BIT_RUN] && q.control[etc_pkg::BIT_EXTSRC] &&
    q.control[etc_pkg::BIT_BYPASS] && !wr_fire;
  endsequence
  sequence s_rise_settled;
    !q.control[etc_pkg::BIT_FALL] && q.pin_sync[2] && q.pin_sync[1] && !q.pin_level;
  endsequence
  sequence s_fall_settled;
    q.control[etc_pkg::BIT_FALL] && !q.pin_sync[2] && !q.pin_sync[1] && q.pin_level;
  endsequence

  AST_RISE_COUNT: assert property (@(posedge clk) disable iff (reset) // RULE_06
    (s_edge_armed and s_rise_settled) |=> q.count[7:0] == 8'($past(q.count[7:0]) + 8'h01))
    else $error("rising pin edge not counted");
  AST_FALL_COUNT: assert property (@(posedge clk) disable iff (reset) // RULE_06
    (s_edge_armed and s_fall_settled) |=> q.count[7:0] == 8'($past(q.count[7:0]) + 8'h01))
    else $error("falling pin edge not counted");
endmodule

/* File: verification/etc_pulse_src.sv */
`timescale 1ns/1ps
// Pulse source on the external count pin; the pin idles low between pulses.
module etc_pulse_src (
  input  wire logic clk,
  output logic      pin
);
  initial pin = 1'b0;

  // Holds each level for twelve clocks so the pin synchroniser sees it.
  task automatic level(input logic v);
    pin <= v;
    repeat (12) @(posedge clk);
  endtask

  // Sends whole pulses, each one high and then low.
  task automatic pulses(input int n);
    repeat (n)
    begin
      level(1'b1);
      level(1'b0);
    end
  endtask
endmodule

/* File: verification/etc_timer_tb_top.sv */
`timescale 1ns/1ps
module etc_timer_tb_top;
  logic        clk;
  logic        reset;
  logic        clk_en;
  logic [3:0]  wstrb;
  logic        pin;
  logic [4:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [7:0]  v, v1;
  int          mismatches, cmp_count, cyc;

  etc_timer u_etc_timer (.clk(clk), .reset(reset), .clk_en(clk_en),
    .external_count_input(pin), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));

  etc_pulse_src u_etc_pulse_src (.clk(clk), .pin(pin));

  // Free-running 40 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      mismatches++;
      complete_run();
    end
  end

  task automatic chk_rng(input string n, input logic [15:0] lo, input logic [15:0] hi,
                         input logic [15:0] g);
    cmp_count++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      $display("CHECK FAILED %s expected %h..%h seen %h", n, lo, hi, g);
      mismatches++;
    end
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    chk_rng(n, e, e, g);
  endtask

  // Looks at the interrupt line between edges, where it has settled.
  task automatic chk_irq(input string n, input logic e);
    @(negedge clk);
    chk(n, 16'(e), 16'(irq));
    @(posedge clk);
  endtask

  // Write: address and data offered together, each dropped once taken.
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0,
                    input logic [3:0] st = 4'hF);
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    b_t = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t)
    begin
      @(negedge clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    // The response channel stays ready, so a following write never toggles it.
    chk("bresp", {14'h0000, er}, {14'h0000, r});
  endtask

  // Read: address held until taken, data captured with rvalid.
  task automatic rd(input logic [4:0] a, output logic [7:0] d, input logic [1:0] er = 2'h0);
    logic ar_t, r_t;
    logic [1:0] r;
    r_t = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t)
    begin
      @(negedge clk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      d = rdata[7:0];
      r = rresp;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
    end
    // The read data channel stays ready, so a following read never toggles it.
    chk("rresp", {14'h0000, er}, {14'h0000, r});
  endtask

  localparam logic [4:0] CTL = 5'(etc_pkg::OFS_CONTROL);
  localparam logic [4:0] LOW = 5'(etc_pkg::OFS_LOW);
  localparam logic [4:0] HIB = 5'(etc_pkg::OFS_HIGH_BUF);
  localparam logic [4:0] STA = 5'(etc_pkg::OFS_STATUS);
  localparam logic [4:0] MSK = etc_pkg::OFS_MASK;

  // Main sequence of tests.
  initial
  begin
    reset = 1'b1;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    clk_en = 1'b1;
    wstrb = 4'hF;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(CTL, v); chk("control", 16'(etc_pkg::RST_CONTROL), 16'(v));
    rd(STA, v); chk("status", 16'h0000, 16'(v));
    rd(MSK, v); chk("mask", 16'h0000, 16'(v));
    rd(5'h14, v, etc_pkg::AXI_SLVERR);
    wr(5'h18, 8'h01, etc_pkg::AXI_SLVERR);
    wr(CTL, 8'h00, etc_pkg::AXI_OKAY, 4'hE);
    rd(CTL, v); chk("strobe_off", 16'(etc_pkg::RST_CONTROL), 16'(v));
    $display("test reset_map done");
    wr(CTL, 8'hC8);
    wr(LOW, 8'h00);
    repeat (40) @(posedge clk);
    rd(LOW, v); chk_rng("timer", 16'h0007, 16'h000A, 16'(v));
    $display("test timer done");
    rd(LOW, v1);
    clk_en <= 1'b0;
    repeat (100) @(posedge clk);
    clk_en <= 1'b1;
    rd(LOW, v); chk_rng("frozen", 16'(v1), 16'(v1) + 16'h0001, 16'(v));
    $display("test freeze done");
    for (int c = 0; c < 8; c++)
    begin
      wr(CTL, 8'hC0 | 8'(c));
      wr(LOW, 8'h00);
      repeat (4 * (2 << c) * 8) @(posedge clk);
      rd(LOW, v); chk_rng("prescaled", 16'h0006, 16'h0009, 16'(v));
    end
    $display("test prescaler done");
    wr(CTL, 8'h88);
    wr(STA, 8'h01);
    wr(HIB, 8'hFF);
    wr(LOW, 8'hF0);
    rd(LOW, v); chk_rng("low16", 16'h00F0, 16'h00F3, 16'(v));
    rd(HIB, v); chk("high16", 16'h00FF, 16'(v));
    rd(STA, v); chk("status16", 16'h0000, 16'(v));
    repeat (80) @(posedge clk);
    rd(STA, v); chk("wrap16", 16'h0001, 16'(v));
    rd(LOW, v); chk_rng("low_wrap", 16'h0000, 16'h000F, 16'(v));
    rd(HIB, v); chk("high_wrap", 16'h0000, 16'(v));
    chk_irq("irq_masked", 1'b0);
    wr(STA, 8'h00);
    rd(STA, v); chk("sticky", 16'h0001, 16'(v));
    wr(MSK, 8'h01);
    repeat (2) @(posedge clk);
    chk_irq("irq_on", 1'b1);
    wr(STA, 8'h01);
    repeat (2) @(posedge clk);
    chk_irq("irq_off", 1'b0);
    $display("test sixteen_bit done");
    wr(CTL, 8'hC8);
    wr(LOW, 8'hFC);
    repeat (40) @(posedge clk);
    rd(STA, v); chk("wrap8", 16'h0001, 16'(v));
    wr(CTL, 8'h48);
    wr(STA, 8'h01);
    rd(LOW, v1);
    repeat (100) @(posedge clk);
    rd(LOW, v); chk("halted", 16'(v1), 16'(v));
    rd(STA, v); chk("halt_ovf", 16'h0000, 16'(v));
    $display("test halt done");
    wr(CTL, 8'hE8);
    wr(LOW, 8'h00);
    u_etc_pulse_src.level(1'b1);
    rd(LOW, v); chk("rise_cnt", 16'h0001, 16'(v));
    u_etc_pulse_src.level(1'b0);
    rd(LOW, v); chk("rise_hold", 16'h0001, 16'(v));
    wr(CTL, 8'hF8);
    wr(LOW, 8'h00);
    u_etc_pulse_src.level(1'b1);
    rd(LOW, v); chk("fall_hold", 16'h0000, 16'(v));
    u_etc_pulse_src.level(1'b0);
    u_etc_pulse_src.pulses(3);
    rd(LOW, v); chk("fall_cnt", 16'h0004, 16'(v));
    $display("test external done");
    complete_run();
  end
endmodule
